// File: hdl/sreg_drv_pkg.sv
// constants and carrier types for the serial-in latched driver
// Overview of operation
// - A twelve-stage shift register takes the serial input into stage one on each serial clock rise.
// - On each later rise every stage passes its bit one stage toward the serial output.
// - While strobe is high each latch copies its shift register stage.
// - The latches keep following the shift register for as long as strobe stays high.
// - While blanking is high every parallel output is driven low.
// - Blanking never changes the latch contents.
// - While blanking is low each output follows its own latch.
// - The last shift register stage is presented on the serial data output.
package sreg_drv_pkg;
	localparam int STAGES = 12;
	localparam int FIFO_DEPTH = 16;
	localparam logic [STAGES-1:0] SHIFT_RST = 12'h000;
	localparam logic [STAGES-1:0] LATCH_RST = 12'h000;
	localparam logic [1:0] SYNC_RST = 2'h0;

	typedef logic [STAGES-1:0] word_t;

	typedef struct packed {
		logic clk_pin;
		logic data_pin;
		logic strobe_pin;
		logic blank_pin;
	} pins_s;
endpackage : sreg_drv_pkg

// File: hdl/sreg_drv_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module sreg_drv_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// read side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sreg_drv_fifo

// File: hdl/sreg_drv.sv
// serial-in latched parallel driver logic
`timescale 1ns/1ps
module sreg_drv
	import sreg_drv_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// controller pins
	input wire sreg_drv_pkg::pins_s pins,
	// driver and cascade outputs
	output sreg_drv_pkg::word_t par_out,
	output logic ser_out
);
	import sreg_drv_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// reset release
	logic [1:0] rst_sync_q;
	logic rst_n;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rst_sync_q <= SYNC_RST;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	pins_s meta_q;
	pins_s sync_q;
	logic sclk_last_q;
	logic rise;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
			sclk_last_q <= 1'b0;
		end
		else
		begin
			meta_q <= pins;
			sync_q <= meta_q;
			sclk_last_q <= sync_q.clk_pin;
		end
	end
	// data rides the same two-stage delay as the clock, keeping setup order
	assign rise = sync_q.clk_pin && !sclk_last_q;

	////////////////////////////////////////////////////////////////////////
	// shift register
	word_t shift_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			shift_q <= SHIFT_RST;
		else if (rise)
			shift_q <= {shift_q[STAGES-2:0], sync_q.data_pin};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ser_out <= 1'b0;
		else
			ser_out <= shift_q[STAGES-1];
	end

	////////////////////////////////////////////////////////////////////////
	// strobe path: snapshots buffered so the latch sees every transparent update
	word_t fifo_out;
	logic fifo_valid;
	logic fifo_in_ready;
	sreg_drv_fifo #(
		.WIDTH(STAGES),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(sys_clk),
		.rst_n(rst_n),
		.in_data(shift_q),
		.in_valid(sync_q.strobe_pin),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(1'b1)
	);

	word_t latch_q;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			latch_q <= LATCH_RST;
		else if (fifo_valid)
			latch_q <= fifo_out;
	end

	////////////////////////////////////////////////////////////////////////
	// output stage
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			par_out <= '0;
		else if (sync_q.blank_pin)
			par_out <= '0;
		else
			par_out <= latch_q;
	end
endmodule : sreg_drv

// File: dv/sreg_drv_chk.sv
// port checker for the serial-in latched driver
`timescale 1ns/1ps
module sreg_drv_chk
	import sreg_drv_pkg::*;
(
	// watched ports
	input wire logic sys_clk,
	input wire logic nrst,
	input wire sreg_drv_pkg::pins_s pins,
	input wire sreg_drv_pkg::word_t par_out,
	input wire logic ser_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	word_t sh_q;
	logic ck_q, bk_q, calm;
	assign calm = pins.strobe_pin && !pins.blank_pin && pins.clk_pin == ck_q;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			{sh_q, ck_q, bk_q} <= 14'h0000;
		else
		begin
			{ck_q, bk_q} <= {pins.clk_pin, pins.blank_pin};
			if (pins.clk_pin && !ck_q)
				sh_q <= {sh_q[10:0], pins.data_pin};
		end
	property keep_p;
		word_t v;
		((!pins.strobe_pin && !pins.blank_pin)[*8], v = par_out) ##1 (!pins.strobe_pin)[*8]
			##1 (!pins.strobe_pin && !pins.blank_pin)[*8] |-> par_out == v;
	endproperty
	ser_last_a: assert property ($rose(pins.clk_pin) |-> ##6 ser_out == sh_q[11])
		else $error("ser_out bad");
	ser_move_a: assert property ($rose(pins.clk_pin) |-> ##6 ser_out == $past(sh_q[10], 6))
		else $error("shift bad");
	ser_hold_a: assert property ((pins.clk_pin == ck_q)[*6] |-> $stable(ser_out))
		else $error("ser_out moved");
	blank_low_a: assert property (pins.blank_pin[*5] |-> par_out == 12'h000)
		else $error("blank bad");
	latch_hold_a: assert property ((!pins.strobe_pin && pins.blank_pin == bk_q)[*8] |-> $stable(par_out))
		else $error("latch moved");
	par_follow_a: assert property (calm[*8] ##1 calm[*4] |-> par_out == sh_q)
		else $error("par_out bad");
	first_bit_a: assert property (calm[*8] ##1 calm[*4] |-> par_out[0] == sh_q[0])
		else $error("stage one bad");
	blank_keep_a: assert property (keep_p)
		else $error("latch lost");
	cover property (calm[*8]);
	cover property ($rose(pins.blank_pin));
	cover property ($fell(pins.strobe_pin));
endmodule : sreg_drv_chk
bind sreg_drv sreg_drv_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .pins(pins),
	.par_out(par_out), .ser_out(ser_out));

// File: dv/sreg_ctrl.sv
// controller model driving the serial pins
`timescale 1ns/1ps
module sreg_ctrl
	import sreg_drv_pkg::*;
(
	// clock in, pins out
	input wire logic sys_clk,
	output sreg_drv_pkg::pins_s pins
);
	initial pins = 4'h1;
	task automatic send(input logic b);
		@(posedge sys_clk) pins.data_pin <= b;
		@(posedge sys_clk) pins.clk_pin <= 1'h1;
		@(posedge sys_clk) pins.data_pin <= ~b;
		repeat (3) @(posedge sys_clk);
		pins.clk_pin <= 1'h0;
		repeat (4) @(posedge sys_clk);
	endtask : send
	task automatic ctl(input logic stb, input logic blk);
		@(posedge sys_clk) {pins.strobe_pin, pins.blank_pin} <= {stb, blk};
	endtask : ctl
endmodule : sreg_ctrl

// File: dv/tb.sv
// self-checking bench for the serial driver
`timescale 1ns/1ps
module tb;
	import sreg_drv_pkg::*;
	logic sys_clk = 1'h0, nrst = 1'h0, ser_out;
	pins_s pins;
	word_t par_out;
	int bad_count = 0, n_compared = 0, sh = 0, lat = 0, cyc = 0;
	logic [31:0] rng = 32'h6810;
	sreg_ctrl u_ctrl (.sys_clk(sys_clk), .pins(pins));
	sreg_drv u_dut (.sys_clk(sys_clk), .nrst(nrst), .pins(pins), .par_out(par_out),
		.ser_out(ser_out));
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic check(input string n, input word_t s, input word_t e);
		n_compared++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		t = t ^ (t << 5);
		return t;
	endfunction : xorshift
	task automatic load(input logic stb, input logic blk);
		u_ctrl.ctl(stb, blk);
		repeat (12)
		begin
			rng = xorshift(rng);
			u_ctrl.send(rng[0]);
			sh = ((sh << 1) | rng[0]) & 32'hFFF;
			lat = stb ? sh : lat;
		end
	endtask : load
	task automatic look(input logic stb, input logic blk);
		u_ctrl.ctl(stb, blk);
		repeat (16) @(posedge sys_clk);
		check("par_out", par_out, blk ? 12'h000 : word_t'(lat));
		check("ser_out", word_t'(ser_out), word_t'(sh >> 11));
	endtask : look
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 9000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (16) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		load(1'h0, 1'h0);
		look(1'h0, 1'h0);
		load(1'h1, 1'h1);
		look(1'h1, 1'h1);
		look(1'h1, 1'h0);
		look(1'h0, 1'h0);
		load(1'h0, 1'h0);
		look(1'h0, 1'h1);
		look(1'h0, 1'h0);
		tally_and_finish();
	end
endmodule : tb
